/* File: pkg/spi_port_pkg.sv */
//**************************************************************
// spi port package
//**************************************************************
// Purpose: shared constants and types of the serial host port
// Assumes: 8-bit serial frames, most significant bit first
// Notes:   offsets are register addresses on the serial link
package spi_port_pkg;
  // fifo geometry
  localparam int unsigned FIFO_DEPTH = 96;
  localparam int unsigned PTR_W      = 7;
  localparam logic [6:0]  PTR_LAST   = 7'h5f;
  localparam logic [6:0]  FIFO_FULL  = 7'h60;
  localparam logic [6:0]  PTR_ONE    = 7'h01;
  // header mode bits
  localparam logic [1:0]  MODE_REG_WR = 2'h0;
  localparam logic [1:0]  MODE_REG_RD = 2'h1;
  localparam logic [1:0]  MODE_FIFO   = 2'h2;
  localparam logic [1:0]  MODE_CMD    = 2'h3;
  // trailer_code_bits of a fifo header
  localparam logic [5:0]  TRAIL_LOAD  = 6'h00;
  localparam logic [5:0]  TRAIL_READ  = 6'h3f;
  // register addresses and reset byte
  localparam logic [5:0]  ADDR_MASK_MAIN = 6'h14;
  localparam logic [5:0]  ADDR_MASK_TL   = 6'h15;
  localparam logic [5:0]  ADDR_MASK_FW   = 6'h16;
  localparam logic [5:0]  ADDR_IRQ_MAIN  = 6'h17;
  localparam logic [5:0]  ADDR_IRQ_TL    = 6'h18;
  localparam logic [5:0]  ADDR_IRQ_FW    = 6'h19;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  // bit counter value of the last bit of a byte
  localparam logic [2:0]  BIT_LAST = 3'h7;
  // main source bit set by completion of a lasting command
  localparam int unsigned CMD_DONE_SRC = 5;
  // toggle and select level indices crossing from link to system clock
  localparam int unsigned TG_FWR  = 0;
  localparam int unsigned TG_FADV = 1;
  localparam int unsigned TG_FCOM = 2;
  localparam int unsigned TG_RWR  = 3;
  localparam int unsigned TG_RRD  = 4;
  localparam int unsigned TG_CMD  = 5;
  localparam int unsigned TG_SS   = 6;
  localparam int unsigned TG_N    = 6;
  // link state
  typedef enum logic [5:0] {
    ST_HDR   = 6'b000001,
    ST_RREG  = 6'b000010,
    ST_WREG  = 6'b000100,
    ST_LOAD  = 6'b001000,
    ST_FREAD = 6'b010000,
    ST_SKIP  = 6'b100000
  } link_st_t;
endpackage

/* File: design/sync2.sv */
//**************************************************************
// two-stage synchroniser
//**************************************************************
// Purpose: bring levels and toggles into the system clock
// Assumes: each input bit changes slower than two clocks
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module sync2 #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // two flops in series
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_q <= RST_VAL;
      o_q    <= RST_VAL;
    end
    else
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

/* File: design/fifo_mem.sv */
//**************************************************************
// fifo byte memory
//**************************************************************
// Purpose: storage of the data fifo with registered read
// Assumes: one write and one read port on one clock
// Notes:   read data trails the read address by one clock
`timescale 1ns/1ns
module fifo_mem #(
  parameter int unsigned DEPTH = 96,
  parameter int unsigned AW    = 7
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];

  // array write
  always_ff @(posedge i_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
  end

  // registered read
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_rdata <= spi_port_pkg::RST_BYTE;
    else
      o_rdata <= mem[i_raddr];
  end
endmodule

/* File: design/spi_fifo_command_irq_port.sv */
//**************************************************************
// serial host port with fifo, direct commands and interrupts
//**************************************************************
// Purpose: slave serial port, data fifo, command strobe, irq
// Assumes: master keeps the serial framing and timing
// Notes:   serial side runs on sclk; link state and miso reset while select high
// Functional notes
// - Header 10 000000 loads every following whole byte into the fifo.
// - Partial byte at select rise during load is dropped.
// - Header 10 111111 returns fifo bytes for the rest of select.
// - Fifo read bits leave on sclk rising edges like register reads.
// - Partial byte at select rise during read stays first unread.
// - Direct command: header 11 then six code bits, msb first.
// - Command starts at falling edge of its last bit.
// - Lasting command completion raises an interrupt.
// - After an immediate command a new header follows, select low.
// - An event sets its main source bit and raises irq.
// - Reading an interrupt register clears it, pointers excepted.
// - Pointer bit clears only when its auxiliary register is read.
// - Irq falls only once every pending bit has been read.
// - Mask bit blocks irq, status bit still sets.
// - Select high resets the port; first header picks the mode.
// - Mosi on falling, miso on rising edges; miso off unless data.
// - Fifo transfers act only with enable and stable oscillator; core push and pop act without them.
`timescale 1ns/1ns
module spi_fifo_command_irq_port (
  // system clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // serial link
  input  wire logic       i_sclk,
  input  wire logic       i_ss_n,
  input  wire logic       i_mosi,
  output logic            o_miso,
  output logic            o_miso_oe,
  // fifo core side
  input  wire logic       i_op_en,
  input  wire logic       i_osc_stable,
  input  wire logic       i_push,
  input  wire logic [7:0] i_push_data,
  input  wire logic       i_pop,
  output logic      [7:0] o_head_data,
  output logic      [6:0] o_fifo_count,
  // direct commands
  output logic            o_cmd_stb,
  output logic      [5:0] o_cmd_code,
  input  wire logic       i_cmd_done,
  // interrupt sources and request
  input  wire logic [5:0] i_main_evt,
  input  wire logic [7:0] i_tl_evt,
  input  wire logic [7:0] i_fw_evt,
  output logic            o_irq
);

  //**************************************************************
  // declarations
  //**************************************************************
  spi_port_pkg::link_st_t st_q;
  logic [2:0]  bit_q;
  logic [6:0]  rx_q;
  logic [7:0]  tx_q;
  logic [5:0]  addr_q;
  logic [5:0]  tgl_q;
  logic [7:0]  hold_q;
  logic [5:0]  done_addr_q;
  logic [5:0]  code_q;
  logic [7:0]  byte_w;
  logic        last_w;
  logic [6:0]  tg_s;
  logic [5:0]  tg_p_q;
  logic [5:0]  ev;
  logic        ss_idle;
  logic [6:0]  wr_q, rd_q, peek_q, count_q, ahead_q;
  logic [6:0]  rd_d, peek_d, count_d, ahead_d;
  logic        load_pend_q, fifo_ok, full, push_int, spi_wr, we;
  logic        adv, com, int_pop, pop_any;
  logic [7:0]  mem_rd;
  logic [5:0]  src_q, shadow_src_q, evt_main, clr_main;
  logic [7:0]  tl_q, fw_q, shadow_tl_q, shadow_fw_q;
  logic [1:0]  shadow_ptr_q;
  logic [7:0]  mask_main_q, mask_tl_q, mask_fw_q;
  logic        pending;

  // next fifo pointer with wrap
  function automatic logic [6:0] nxt(input logic [6:0] p);
    nxt = (p == spi_port_pkg::PTR_LAST) ? '0 : p + spi_port_pkg::PTR_ONE;
  endfunction

  // readable register view; held steady during a transaction
  function automatic logic [7:0] reg_val(input logic [5:0] a);
    case (a)
      spi_port_pkg::ADDR_MASK_MAIN: reg_val = mask_main_q;
      spi_port_pkg::ADDR_MASK_TL:   reg_val = mask_tl_q;
      spi_port_pkg::ADDR_MASK_FW:   reg_val = mask_fw_q;
      spi_port_pkg::ADDR_IRQ_MAIN:  reg_val = {shadow_src_q, shadow_ptr_q};
      spi_port_pkg::ADDR_IRQ_TL:    reg_val = shadow_tl_q;
      spi_port_pkg::ADDR_IRQ_FW:    reg_val = shadow_fw_q;
      default:                      reg_val = spi_port_pkg::RST_BYTE;
    endcase
  endfunction

  //**************************************************************
  // link side, sclk domain
  //**************************************************************
  assign byte_w = {rx_q, i_mosi};
  assign last_w = (bit_q == spi_port_pkg::BIT_LAST);

  always_ff @(negedge i_sclk or posedge i_ss_n)
  begin
    if (i_ss_n)
    begin
      st_q   <= spi_port_pkg::ST_HDR;
      bit_q  <= '0;
      rx_q   <= '0;
      tx_q   <= spi_port_pkg::RST_BYTE;
      addr_q <= '0;
    end
    else
    begin
      bit_q <= bit_q + 3'h1;
      rx_q  <= byte_w[6:0];
      tx_q  <= {tx_q[6:0], 1'b0};
      if (last_w)
      begin
        case (st_q)
          spi_port_pkg::ST_HDR:
          begin
            addr_q <= byte_w[5:0];
            case (byte_w[7:6])
              spi_port_pkg::MODE_REG_WR: st_q <= spi_port_pkg::ST_WREG;
              spi_port_pkg::MODE_REG_RD:
              begin
                st_q <= spi_port_pkg::ST_RREG;
                tx_q <= reg_val(byte_w[5:0]);
              end
              spi_port_pkg::MODE_FIFO:
              begin
                if (byte_w[5:0] == spi_port_pkg::TRAIL_LOAD)
                  st_q <= spi_port_pkg::ST_LOAD;
                else if (byte_w[5:0] == spi_port_pkg::TRAIL_READ)
                begin
                  st_q <= spi_port_pkg::ST_FREAD;
                  tx_q <= o_head_data;
                end
                else
                  st_q <= spi_port_pkg::ST_SKIP;
              end
              // chain: next byte is a header
              default: st_q <= spi_port_pkg::ST_HDR;
            endcase
          end
          spi_port_pkg::ST_RREG:
          begin
            addr_q <= addr_q + 6'h01;
            tx_q   <= reg_val(addr_q + 6'h01);
          end
          spi_port_pkg::ST_WREG: addr_q <= addr_q + 6'h01;
          // next fifo byte loaded for output
          spi_port_pkg::ST_FREAD: tx_q <= o_head_data;
          default: st_q <= st_q;
        endcase
      end
    end
  end

  // toggles and held data; only whole bytes produce a toggle
  always_ff @(negedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tgl_q       <= '0;
      hold_q      <= spi_port_pkg::RST_BYTE;
      done_addr_q <= '0;
      code_q      <= '0;
    end
    else if (last_w)
    begin
      case (st_q)
        spi_port_pkg::ST_HDR:
        begin
          // command issued at last falling edge
          if (byte_w[7:6] == spi_port_pkg::MODE_CMD)
          begin
            tgl_q[spi_port_pkg::TG_CMD] <= ~tgl_q[spi_port_pkg::TG_CMD];
            code_q <= byte_w[5:0];
          end
          else if (byte_w == {spi_port_pkg::MODE_FIFO, spi_port_pkg::TRAIL_READ})
            tgl_q[spi_port_pkg::TG_FADV] <= ~tgl_q[spi_port_pkg::TG_FADV];
        end
        spi_port_pkg::ST_RREG:
        begin
          tgl_q[spi_port_pkg::TG_RRD] <= ~tgl_q[spi_port_pkg::TG_RRD];
          done_addr_q <= addr_q;
        end
        spi_port_pkg::ST_WREG:
        begin
          tgl_q[spi_port_pkg::TG_RWR] <= ~tgl_q[spi_port_pkg::TG_RWR];
          done_addr_q <= addr_q;
          hold_q      <= byte_w;
        end
        // only a completed byte reaches the fifo
        spi_port_pkg::ST_LOAD:
        begin
          tgl_q[spi_port_pkg::TG_FWR] <= ~tgl_q[spi_port_pkg::TG_FWR];
          hold_q <= byte_w;
        end
        // commit only after a whole byte left
        spi_port_pkg::ST_FREAD:
        begin
          tgl_q[spi_port_pkg::TG_FCOM] <= ~tgl_q[spi_port_pkg::TG_FCOM];
          tgl_q[spi_port_pkg::TG_FADV] <= ~tgl_q[spi_port_pkg::TG_FADV];
        end
        default: tgl_q <= tgl_q;
      endcase
    end
  end

  // miso driven on rising edge, enabled only with data
  always_ff @(posedge i_sclk or posedge i_ss_n)
  begin
    if (i_ss_n)
    begin
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end
    else
    begin
      o_miso    <= tx_q[7];
      o_miso_oe <= (st_q == spi_port_pkg::ST_RREG) || (st_q == spi_port_pkg::ST_FREAD);
    end
  end

  //**************************************************************
  // crossing into system clock
  //**************************************************************
  sync2 #(
    .W       (7),
    .RST_VAL (7'h40)
  ) u_sync (
    .i_clk   (i_clk_sys),
    .i_rst_n (i_rst_n),
    .i_d     ({i_ss_n, tgl_q}),
    .o_q     (tg_s)
  );

  assign ev      = tg_s[spi_port_pkg::TG_N-1:0] ^ tg_p_q;
  assign ss_idle = tg_s[spi_port_pkg::TG_SS];

  // previous toggle levels
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      tg_p_q <= '0;
    else
      tg_p_q <= tg_s[spi_port_pkg::TG_N-1:0];
  end

  //**************************************************************
  // fifo, system domain
  //**************************************************************
  // serial fifo loads, serial read advance and head data need enable and stable oscillator
  assign fifo_ok  = i_op_en && i_osc_stable;
  assign full     = (count_q == spi_port_pkg::FIFO_FULL);
  assign push_int = i_push && !full;
  assign spi_wr   = load_pend_q && !i_push && fifo_ok && !full;
  assign we       = push_int || spi_wr;
  assign adv      = ev[spi_port_pkg::TG_FADV] && fifo_ok && (count_q > ahead_q);
  assign com      = ev[spi_port_pkg::TG_FCOM] && (ahead_q != '0);
  assign int_pop  = i_pop && (count_q != '0) && (ahead_q == '0) && !adv;
  assign pop_any  = com || int_pop;
  assign rd_d     = pop_any ? nxt(rd_q) : rd_q;
  // unfinished read bytes rewind when select rises
  assign peek_d   = (ss_idle || int_pop) ? rd_d : (adv ? nxt(peek_q) : peek_q);
  assign count_d  = count_q + {6'h00, we} - {6'h00, pop_any};
  assign ahead_d  = ss_idle ? '0 : ahead_q + {6'h00, adv} - {6'h00, com};

  fifo_mem #(
    .DEPTH (spi_port_pkg::FIFO_DEPTH),
    .AW    (spi_port_pkg::PTR_W)
  ) u_mem (
    .i_clk   (i_clk_sys),
    .i_rst_n (i_rst_n),
    .i_we    (we),
    .i_waddr (wr_q),
    .i_wdata (push_int ? i_push_data : hold_q),
    .i_raddr (peek_q),
    .o_rdata (mem_rd)
  );

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      wr_q         <= '0;
      rd_q         <= '0;
      peek_q       <= '0;
      count_q      <= '0;
      ahead_q      <= '0;
      load_pend_q  <= 1'b0;
      o_head_data  <= spi_port_pkg::RST_BYTE;
      o_fifo_count <= '0;
    end
    else
    begin
      wr_q         <= we ? nxt(wr_q) : wr_q;
      rd_q         <= rd_d;
      peek_q       <= peek_d;
      count_q      <= count_d;
      ahead_q      <= ahead_d;
      load_pend_q  <= ev[spi_port_pkg::TG_FWR] || (load_pend_q && i_push);
      o_head_data  <= (fifo_ok && count_q > ahead_q) ? mem_rd : spi_port_pkg::RST_BYTE;
      o_fifo_count <= count_d;
    end
  end

  //**************************************************************
  // commands and interrupts, system domain
  //**************************************************************
  // lasting command completion is a main source
  assign evt_main = i_main_evt | (6'h01 << spi_port_pkg::CMD_DONE_SRC & {6{i_cmd_done}});
  assign clr_main = (ev[spi_port_pkg::TG_RRD] && done_addr_q == spi_port_pkg::ADDR_IRQ_MAIN)
                    ? shadow_src_q : '0;
  assign pending  = |(src_q & ~mask_main_q[7:2]) || |(tl_q & ~mask_tl_q) || |(fw_q & ~mask_fw_q);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_cmd_stb  <= 1'b0;
      o_cmd_code <= '0;
    end
    else
    begin
      o_cmd_stb  <= ev[spi_port_pkg::TG_CMD];
      o_cmd_code <= ev[spi_port_pkg::TG_CMD] ? code_q : o_cmd_code;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      src_q <= '0;
      tl_q  <= '0;
      fw_q  <= '0;
    end
    else
    begin
      src_q <= (src_q & ~clr_main) | evt_main;
      tl_q  <= (ev[spi_port_pkg::TG_RRD] && done_addr_q == spi_port_pkg::ADDR_IRQ_TL)
               ? (tl_q & ~shadow_tl_q) | i_tl_evt : tl_q | i_tl_evt;
      fw_q  <= (ev[spi_port_pkg::TG_RRD] && done_addr_q == spi_port_pkg::ADDR_IRQ_FW)
               ? (fw_q & ~shadow_fw_q) | i_fw_evt : fw_q | i_fw_evt;
    end
  end

  // snapshot while idle; pointers follow auxiliary contents
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      shadow_src_q <= '0;
      shadow_ptr_q <= '0;
      shadow_tl_q  <= '0;
      shadow_fw_q  <= '0;
    end
    else if (ss_idle)
    begin
      shadow_src_q <= src_q;
      shadow_ptr_q <= {|tl_q, |fw_q};
      shadow_tl_q  <= tl_q;
      shadow_fw_q  <= fw_q;
    end
  end

  // mask registers written over the link
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      mask_main_q <= spi_port_pkg::RST_BYTE;
      mask_tl_q   <= spi_port_pkg::RST_BYTE;
      mask_fw_q   <= spi_port_pkg::RST_BYTE;
    end
    else if (ev[spi_port_pkg::TG_RWR])
    begin
      if (done_addr_q == spi_port_pkg::ADDR_MASK_MAIN)
        mask_main_q <= hold_q;
      if (done_addr_q == spi_port_pkg::ADDR_MASK_TL)
        mask_tl_q <= hold_q;
      if (done_addr_q == spi_port_pkg::ADDR_MASK_FW)
        mask_fw_q <= hold_q;
    end
  end

  // request pin follows unmasked pending bits
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= pending;
  end

  //**************************************************************
  // assertions
  //**************************************************************
  a_irq_falls_idle: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) !pending |=> !o_irq)
    else $error("irq high with nothing pending");
  a_irq_rises_evt: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (|(i_main_evt & ~mask_main_q[7:2]) && !ev[spi_port_pkg::TG_RWR]) |-> ##2 o_irq)
    else $error("event did not raise irq");
  a_masked_status_set: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) i_main_evt[0] |=> src_q[0])
    else $error("status bit not set under mask");
  a_read_clears_main: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (clr_main != '0 && evt_main == '0) |=> (src_q & $past(clr_main)) == '0)
    else $error("read did not clear main status");
  a_ptr_tracks_aux: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (ss_idle && $past(ss_idle)) |-> shadow_ptr_q[1] == $past(|tl_q))
    else $error("pointer bit out of step");
  a_load_counts: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (spi_wr && !pop_any) |=> count_q == $past(count_q) + 7'h01)
    else $error("fifo load not counted");
  a_read_rewinds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    ss_idle [*2] |-> (peek_q == rd_q) && (ahead_q == '0))
    else $error("unread byte not restored");
  a_cmd_one_pulse: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    ev[spi_port_pkg::TG_CMD] |=> o_cmd_stb ##1 !o_cmd_stb)
    else $error("command strobe wrong");
  a_partial_dropped: assert property (
    @(negedge i_sclk) disable iff (i_ss_n)
    (st_q == spi_port_pkg::ST_LOAD && !last_w)
    |=> tgl_q[spi_port_pkg::TG_FWR] == $past(tgl_q[spi_port_pkg::TG_FWR]))
    else $error("partial byte written");
  a_miso_quiet: assert property (
    @(posedge i_sclk) disable iff (i_ss_n)
    (st_q == spi_port_pkg::ST_LOAD || st_q == spi_port_pkg::ST_WREG) |=> !o_miso_oe)
    else $error("miso driven without data");
endmodule

/* File: testbench/spi_master_model.sv */
//********************
// serial master model
//********************
// Purpose: master that frames bytes on the host port
// Assumes: sclk idles low, 32 ns per bit, msb first
// Notes:   mosi turns to its inverse whenever select falls or rises
`timescale 1ns/1ns
module spi_master_model (
  // serial link
  output logic      o_sclk,
  output logic      o_ss_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  // idle link
  initial
  begin
    // non-blocking so the select edge reaches the port's async reset
    o_sclk <= 1'b0;
    o_ss_n <= 1'b1;
    o_mosi <= 1'b0;
  end
  task automatic sel(input logic lvl);
    #300;
    o_ss_n = lvl;
    o_mosi = ~o_mosi;
    #300;
  endtask
  // n bits msb first, miso taken at falling edge
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      #1 o_mosi = tx[i];
      #15 o_sclk = 1'b1;
      #16 rx[i] = i_miso;
      o_sclk = 1'b0;
    end
  endtask
endmodule

/* File: testbench/testbench.sv */
//********************
// host port bench
//********************
// Purpose: self-checking bench of the serial host port
// Assumes: master model drives the link
// Notes:   expected bytes follow the header and irq layout
`timescale 1ns/1ns
module testbench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b1;
  logic       osc_stable = 1'b1;
  logic       sclk, ss_n, mosi, miso, miso_oe, miso_line, irq, cmd_stb;
  logic       op_en = 1'b1;
  logic [6:0] count;
  logic [5:0] cmd_code, cmd_seen, main_evt = 6'h00;
  logic [7:0] tl_evt = 8'h00, fw_evt = 8'h00, head, rx, n_cmd = 8'h00;
  logic       cmd_done = 1'b0;
  int         n_mismatch = 0;
  int         num_checks = 0;
  // 250 MHz system clock
  always #2 clk = ~clk;
  // released miso falls to the pull-down
  assign miso_line = miso_oe ? miso : 1'b0;
  spi_master_model master_u (.o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(miso_line));
  spi_fifo_command_irq_port dut_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_ss_n(ss_n), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(miso_oe), .i_op_en(op_en), .i_osc_stable(osc_stable),
    .i_push(1'b0), .i_push_data(8'h00), .i_pop(1'b0), .o_head_data(head),
    .o_fifo_count(count), .o_cmd_stb(cmd_stb), .o_cmd_code(cmd_code),
    .i_cmd_done(cmd_done), .i_main_evt(main_evt), .i_tl_evt(tl_evt),
    .i_fw_evt(fw_evt), .o_irq(irq));
  // count command strobes
  always @(posedge clk)
    if (cmd_stb === 1'b1)
    begin
      n_cmd <= n_cmd + 8'h01;
      cmd_seen <= cmd_code;
    end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one framed transfer of up to four bytes
  task automatic frame(input logic [31:0] b, input int nb, input int tail);
    master_u.sel(1'b0);
    for (int k = 0; k < nb; k++)
      master_u.xfer(b[31-8*k -: 8], (k == nb - 1) ? tail : 8, rx);
    master_u.sel(1'b1);
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse(input logic [5:0] m, input logic [7:0] t, input logic [7:0] f,
                       input logic d);
    @(posedge clk);
    main_evt <= m;
    tl_evt <= t;
    fw_evt <= f;
    cmd_done <= d;
    @(posedge clk);
    main_evt <= 6'h00;
    tl_evt <= 8'h00;
    fw_evt <= 8'h00;
    cmd_done <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd_irq(input logic [7:0] m, input logic [7:0] t, input logic [7:0] f);
    master_u.sel(1'b0);
    master_u.xfer(8'h57, 8, rx);
    master_u.xfer(8'h00, 8, rx);
    check("main irq", rx, m);
    master_u.xfer(8'h00, 8, rx);
    check("aux irq", rx, t);
    master_u.xfer(8'h00, 8, rx);
    check("fault irq", rx, f);
    master_u.sel(1'b1);
    repeat (8) @(posedge clk);
  endtask
  // cut a hang short
  initial
  begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    frame(32'h80a53cff, 4, 4);
    check("count", {1'b0, count}, 8'h02);
    frame(32'hbf000000, 2, 8);
    check("fifo byte", rx, 8'ha5);
    frame(32'hbf000000, 2, 4);
    check("count", {1'b0, count}, 8'h01);
    check("head", head, 8'h3c);
    frame(32'hbf000000, 2, 8);
    check("fifo byte", rx, 8'h3c);
    frame(32'hc5807700, 3, 8);
    check("cmd code", {2'h0, cmd_seen}, 8'h05);
    check("cmd count", n_cmd, 8'h01);
    check("count", {1'b0, count}, 8'h01);
    @(posedge clk);
    op_en <= 1'b0;
    frame(32'h80110000, 2, 8);
    check("count", {1'b0, count}, 8'h01);
    check("head", head, 8'h00);
    op_en <= 1'b1;
    osc_stable <= 1'b0;
    frame(32'hbf000000, 2, 8);
    check("fifo byte", rx, 8'h00);
    check("count", {1'b0, count}, 8'h01);
    osc_stable <= 1'b1;
    pulse(6'h01, 8'h02, 8'h10, 1'b1);
    check("irq", {7'h00, irq}, 8'h01);
    rd_irq(8'h87, 8'h02, 8'h10);
    check("irq", {7'h00, irq}, 8'h00);
    rd_irq(8'h00, 8'h00, 8'h00);
    frame(32'h14040000, 2, 8);
    pulse(6'h01, 8'h00, 8'h00, 1'b0);
    check("irq", {7'h00, irq}, 8'h00);
    rd_irq(8'h04, 8'h00, 8'h00);
    end_of_test();
  end
endmodule
